// ---- design/sttmr_top.sv ----
// System tick timer: registers, down counter, zero flag and interrupt
import sttmr_pkg::*;

// How it works
// - Counter counts down only while the enable control bit is one.
// - Interrupt enable bit lets each count to zero request an interrupt.
// - Clock select one counts every cycle, zero counts every second cycle.
// - Zero flag bit 16 is set on reaching zero, cleared by reading.
// - After zero the counter reloads from reload register bits 23:0.
// - Reading current value register returns the present count.
// - Any write to current value clears counter, and clears zero flag unless a zero arrives that cycle.
// - Calibration register shows the external calibration word fields.
// - Counter is a 24-bit down counter, one step per selected tick.
// - Registers sit at fixed addresses on the core peripheral port.
module sttmr_top #(
    parameter int CNT_W = sttmr_pkg::STTMR_CNT_W,
    parameter int REF_DIV = sttmr_pkg::STTMR_REF_DIV
) (
    // Clock and reset
    input  logic        sys_clk,
    input  logic        rst,
    // Peripheral register port
    input  logic        bus_req,
    input  logic        bus_we,
    input  logic [31:0] bus_addr,
    input  logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic        bus_ack,
    // Calibration word from system configuration
    input  logic [31:0] tick_calibration_source,
    // Interrupt request to the core
    output logic        tick_irq
);
    import sttmr_pkg::*;

    if (CNT_W < 2 || CNT_W > STTMR_CNT_W) begin : g_bad_cnt_w
        $error("sttmr_top: CNT_W must lie in 2..24");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic             enable_q;
    logic             enable_d;
    logic             zero_irq_enable_q;
    logic             zero_irq_enable_d;
    logic             count_clock_select_q;
    logic             count_clock_select_d;
    logic [CNT_W-1:0] reload_q;
    logic [CNT_W-1:0] reload_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             zero_reached_flag_q;
    logic             zero_reached_flag_d;
    logic             irq_q;
    logic             irq_d;
    logic [31:0]      rdata_q;
    logic [31:0]      rdata_d;
    logic             ack_q;
    logic             ack_d;

    logic             tick_en;
    logic             step;
    logic             zero_ev;
    logic             ctrl_wr;
    logic             ctrl_rd;
    logic             reload_wr;
    logic             curr_wr;

    ////////////////////////////////////////////////////////////////////////
    // Count clock enable

    sttmr_tick_gen #(
        .DIV      (REF_DIV)
    ) i_sttmr_tick_gen (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .fast_sel (count_clock_select_q),
        .tick_en  (tick_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register port decode

    // Full address compare, one word per register
    assign ctrl_wr   = bus_req && bus_we && (bus_addr == STTMR_CTRL_ADDR);
    assign ctrl_rd   = bus_req && !bus_we && (bus_addr == STTMR_CTRL_ADDR);
    assign reload_wr = bus_req && bus_we && (bus_addr == STTMR_RELOAD_ADDR);
    assign curr_wr   = bus_req && bus_we && (bus_addr == STTMR_CURR_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // Control and reload registers

    // Only the documented bits are stored
    always_comb begin
        enable_d             = enable_q;
        zero_irq_enable_d    = zero_irq_enable_q;
        count_clock_select_d = count_clock_select_q;
        reload_d             = reload_q;
        if (ctrl_wr) begin
            enable_d             = bus_wdata[STTMR_EN_BIT];
            zero_irq_enable_d    = bus_wdata[STTMR_IRQ_EN_BIT];
            count_clock_select_d = bus_wdata[STTMR_CLK_SEL_BIT];
        end
        if (reload_wr) begin
            reload_d = bus_wdata[CNT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable_q             <= STTMR_CTRL_RST;
            zero_irq_enable_q    <= STTMR_CTRL_RST;
            count_clock_select_q <= STTMR_CTRL_RST;
            reload_q             <= STTMR_RELOAD_RST[CNT_W-1:0];
        end else begin
            enable_q             <= enable_d;
            zero_irq_enable_q    <= zero_irq_enable_d;
            count_clock_select_q <= count_clock_select_d;
            reload_q             <= reload_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Down counter, zero flag and interrupt

    // A counting step needs the enable and a selected tick
    assign step    = enable_q && tick_en;
    assign zero_ev = step && (cnt_q == CNT_W'(1));

    always_comb begin
        cnt_d               = cnt_q;
        zero_reached_flag_d = zero_reached_flag_q;
        if (curr_wr) begin
            cnt_d = '0;
        end else if (step) begin
            if (cnt_q == '0) begin
                cnt_d = reload_q;
            end else begin
                cnt_d = cnt_q - CNT_W'(1);
            end
        end
        // Clear by read or current value write, set wins
        if (ctrl_rd || curr_wr) begin
            zero_reached_flag_d = 1'b0;
        end
        if (zero_ev) begin
            zero_reached_flag_d = 1'b1;
        end
        // One pulse on the tick that reaches zero
        irq_d = zero_ev && zero_irq_enable_q;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q               <= STTMR_CNT_RST[CNT_W-1:0];
            zero_reached_flag_q <= STTMR_CTRL_RST;
            irq_q               <= STTMR_CTRL_RST;
        end else begin
            cnt_q               <= cnt_d;
            zero_reached_flag_q <= zero_reached_flag_d;
            irq_q               <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and acknowledge

    // Reserved bits and unmapped addresses read as zero
    always_comb begin
        rdata_d = rdata_q;
        ack_d   = bus_req;
        if (bus_req && !bus_we) begin
            rdata_d = '0;
            case (bus_addr)
                STTMR_CTRL_ADDR: begin
                    rdata_d[STTMR_EN_BIT]      = enable_q;
                    rdata_d[STTMR_IRQ_EN_BIT]  = zero_irq_enable_q;
                    rdata_d[STTMR_CLK_SEL_BIT] = count_clock_select_q;
                    rdata_d[STTMR_FLAG_BIT]    = zero_reached_flag_q;
                end
                STTMR_RELOAD_ADDR: begin
                    rdata_d[CNT_W-1:0] = reload_q;
                end
                STTMR_CURR_ADDR: begin
                    rdata_d[CNT_W-1:0] = cnt_q;
                end
                STTMR_CALIB_ADDR: begin
                    rdata_d = tick_calibration_source & STTMR_CALIB_MASK;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= STTMR_RDATA_RST;
            ack_q   <= STTMR_CTRL_RST;
        end else begin
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
        end
    end

    // Outputs straight from flip-flops
    assign bus_rdata = rdata_q;
    assign bus_ack   = ack_q;
    assign tick_irq  = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Step from one to zero without a clearing write
    sequence s_wrap_to_zero;
        step && cnt_q == CNT_W'(1) && !curr_wr;
    endsequence

    // Control read while the flag stands and no new zero arrives
    sequence s_flag_read;
        zero_reached_flag_q && ctrl_rd && !zero_ev;
    endsequence

    // Slow tick followed by a cycle still on the slow clock
    sequence s_slow_tick;
        tick_en && !count_clock_select_q ##1 !count_clock_select_q;
    endsequence

    property p_hold_when_off;
        !enable_q && !curr_wr |=> cnt_q == $past(cnt_q);
    endproperty
    a_hold_when_off: assert property (p_hold_when_off)
        else $error("counter moved while disabled");

    property p_irq_on_zero;
        s_wrap_to_zero ##0 zero_irq_enable_q |=> tick_irq && cnt_q == '0;
    endproperty
    a_irq_on_zero: assert property (p_irq_on_zero)
        else $error("no interrupt on reaching zero");

    property p_irq_needs_enable;
        tick_irq |-> $past(zero_irq_enable_q) && $past(cnt_q) == CNT_W'(1);
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable)
        else $error("interrupt without enable or zero");

    property p_slow_clock;
        s_slow_tick |-> !tick_en;
    endproperty
    a_slow_clock: assert property (p_slow_clock)
        else $error("slow clock ticked twice in a row");

    property p_flag_set_then_read;
        s_flag_read
            |=> bus_ack && bus_rdata[STTMR_FLAG_BIT] && !zero_reached_flag_q;
    endproperty
    a_flag_set_then_read: assert property (p_flag_set_then_read)
        else $error("zero flag not shown then cleared");

    property p_reload;
        step && cnt_q == '0 && !curr_wr |=> cnt_q == $past(reload_q);
    endproperty
    a_reload: assert property (p_reload)
        else $error("counter did not reload at zero");

    property p_curr_read;
        bus_req && !bus_we && bus_addr == STTMR_CURR_ADDR
            |=> bus_ack && bus_rdata == 32'($past(cnt_q));
    endproperty
    a_curr_read: assert property (p_curr_read)
        else $error("current value read mismatch");

    property p_curr_write;
        curr_wr && !zero_ev |=> cnt_q == '0 && !zero_reached_flag_q;
    endproperty
    a_curr_write: assert property (p_curr_write)
        else $error("current value write did not clear");

    property p_calib;
        bus_req && !bus_we && bus_addr == STTMR_CALIB_ADDR
            |=> bus_rdata == ($past(tick_calibration_source) & STTMR_CALIB_MASK);
    endproperty
    a_calib: assert property (p_calib)
        else $error("calibration read mismatch");

    property p_decrement;
        step && cnt_q != '0 && !curr_wr |=> cnt_q == $past(cnt_q) - CNT_W'(1);
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("counter did not decrement");

    property p_ack;
        bus_req |=> bus_ack ##1 (bus_ack == $past(bus_req));
    endproperty
    a_ack: assert property (p_ack)
        else $error("register access not acknowledged");

endmodule : sttmr_top

// ---- design/sttmr_pkg.sv ----
// Shared constants for the system tick timer
package sttmr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses on the core private peripheral bus
    localparam logic [31:0] STTMR_BASE_ADDR  = 32'hE000_E000;
    localparam logic [31:0] STTMR_CTRL_ADDR  = 32'hE000_E010;
    localparam logic [31:0] STTMR_RELOAD_ADDR = 32'hE000_E014;
    localparam logic [31:0] STTMR_CURR_ADDR  = 32'hE000_E018;
    localparam logic [31:0] STTMR_CALIB_ADDR = 32'hE000_E01C;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in tick_control_status
    localparam int STTMR_EN_BIT      = 0;
    localparam int STTMR_IRQ_EN_BIT  = 1;
    localparam int STTMR_CLK_SEL_BIT = 2;
    localparam int STTMR_FLAG_BIT    = 16;

    ////////////////////////////////////////////////////////////////////////
    // Field positions in tick_calibration
    localparam int STTMR_TEN_MS_W    = 24;
    localparam int STTMR_INEXACT_CALIBRATION_FLAG_BIT    = 30;
    localparam int STTMR_NO_REFERENCE_CLOCK_FLAG_BIT   = 31;
    localparam logic [31:0] STTMR_CALIB_MASK = 32'hC0FF_FFFF;

    ////////////////////////////////////////////////////////////////////////
    // Widths, ratios and values after reset
    localparam int STTMR_CNT_W       = 24;
    localparam int STTMR_REF_DIV     = 2;
    localparam logic STTMR_CTRL_RST  = 1'b0;
    localparam logic [23:0] STTMR_RELOAD_RST = 24'h00_0000;
    localparam logic [23:0] STTMR_CNT_RST    = 24'h00_0000;
    localparam logic [31:0] STTMR_RDATA_RST  = 32'h0000_0000;

endpackage : sttmr_pkg

// ---- design/sttmr_tick_gen.sv ----
// Count clock enable: every cycle or one cycle in DIV
module sttmr_tick_gen #(
    parameter int DIV = sttmr_pkg::STTMR_REF_DIV
) (
    // Clock and reset
    input  logic sys_clk,
    input  logic rst,
    // Source choice and resulting tick
    input  logic fast_sel,
    output logic tick_en
);
    import sttmr_pkg::*;

    localparam int PH_W = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(DIV - 1);

    if (DIV < 2) begin : g_bad_div
        $error("sttmr_tick_gen: DIV must be at least 2");
    end

    logic [PH_W-1:0] phase_q;
    logic [PH_W-1:0] phase_d;

    ////////////////////////////////////////////////////////////////////////
    // Free running phase of the divided reference
    always_comb begin
        phase_d = (phase_q == PH_LAST) ? '0 : phase_q + PH_W'(1);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Full rate when selected, else last phase only
    assign tick_en = fast_sel | (phase_q == PH_LAST);

endmodule : sttmr_tick_gen

// ---- sim/sttmr_top_tb.sv ----
// Self-checking testbench for the system tick timer
module sttmr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import sttmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Signals
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        bus_req = 1'b0;
    logic        bus_we  = 1'b0;
    logic [31:0] bus_addr  = 32'h0000_0000;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic [31:0] bus_rdata;
    logic        bus_ack;
    logic [31:0] tick_calibration_source = 32'h0000_0004;
    logic        tick_irq;
    logic [31:0] rd;
    logic [31:0] rd_b;
    int          failures    = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    // Clock, 4 ns period
    always #2 sys_clk = ~sys_clk;

    sttmr_top i_sttmr_top (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .bus_req                 (bus_req),
        .bus_we                  (bus_we),
        .bus_addr                (bus_addr),
        .bus_wdata               (bus_wdata),
        .bus_rdata               (bus_rdata),
        .bus_ack                 (bus_ack),
        .tick_calibration_source (tick_calibration_source),
        .tick_irq                (tick_irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Common tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One access: driven after an edge, answer taken one edge later
    task automatic bus(input logic we, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge sys_clk);
        #1;
        bus_req   = 1'b1;
        bus_we    = we;
        bus_addr  = addr;
        bus_wdata = wdata;
        @(posedge sys_clk);
        #1;
        check("bus_ack", {31'h0, bus_ack}, 32'h1);
        rd      = bus_rdata;
        bus_req = 1'b0;
    endtask : bus

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    // Cycles from one interrupt pulse to the next
    task automatic irq_gap(output int gap);
        int i;
        for (i = 0; i < 300 && tick_irq !== 1'b1; i++) idle(1);
        gap = 0;
        do begin
            idle(1);
            gap++;
        end while (tick_irq !== 1'b1 && gap < 300);
    endtask : irq_gap

    // Restart with a reload value, cleared count and a control word
    task automatic start(input logic [31:0] reload, input logic [31:0] ctrl);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h0000_0000);
        bus(1'b1, STTMR_RELOAD_ADDR, reload);
        bus(1'b1, STTMR_CURR_ADDR, 32'h0034_5678);
        bus(1'b1, STTMR_CTRL_ADDR, ctrl);
    endtask : start

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_map;
        bus(1'b0, STTMR_CTRL_ADDR, 32'h0);   check("ctrl rst", rd, 32'h0);
        bus(1'b0, STTMR_RELOAD_ADDR, 32'h0); check("reload rst", rd, 32'h0);
        bus(1'b0, STTMR_CURR_ADDR, 32'h0);   check("curr rst", rd, 32'h0);
        bus(1'b0, 32'hE000_E020, 32'h0);     check("unmapped", rd, 32'h0);
    endtask : t_reset_map

    task automatic t_calib_reserved;
        tick_calibration_source = 32'hFFFF_FFFF;
        bus(1'b1, STTMR_CALIB_ADDR, 32'h0);
        bus(1'b0, STTMR_CALIB_ADDR, 32'h0); check("calib all", rd, 32'hC0FF_FFFF);
        tick_calibration_source = 32'h0000_0004;
        bus(1'b0, STTMR_CALIB_ADDR, 32'h0); check("calib rst", rd, 32'h0000_0004);
        // Calibration count copied into the reload register
        bus(1'b1, STTMR_RELOAD_ADDR, rd & 32'h00FF_FFFF);
        bus(1'b0, STTMR_RELOAD_ADDR, 32'h0); check("reload cal", rd, 32'h4);
        bus(1'b1, STTMR_RELOAD_ADDR, 32'h00FF_FFFF);
        bus(1'b0, STTMR_RELOAD_ADDR, 32'h0); check("reload w", rd, 32'h00FF_FFFF);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h0000_0007);
        bus(1'b0, STTMR_CTRL_ADDR, 32'h0);   check("ctrl w", rd, 32'h0000_0007);
    endtask : t_calib_reserved

    // Interrupt period is reload plus one ticks, halved rate on select 0
    task automatic t_period;
        int gap;
        start(32'h2, 32'h7);
        irq_gap(gap); check("gap fast", gap, 32'd3);
        irq_gap(gap); check("gap fast2", gap, 32'd3);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h3);
        irq_gap(gap);
        irq_gap(gap); check("gap slow", gap, 32'd6);
    endtask : t_period

    // Flag without interrupt, clear by read and by current write
    task automatic t_flag;
        int n;
        start(32'h14, 32'h5);
        n = 0;
        repeat (40) begin
            idle(1);
            if (tick_irq === 1'b1) n++;
        end
        check("irq masked", n, 32'd0);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h4);
        bus(1'b0, STTMR_CTRL_ADDR, 32'h0); check("flag set", rd, 32'h0001_0004);
        bus(1'b0, STTMR_CTRL_ADDR, 32'h0); check("flag rd clr", rd, 32'h0000_0004);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h5);
        idle(30);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h4);
        bus(1'b1, STTMR_CURR_ADDR, 32'h00AB_CDEF);
        bus(1'b0, STTMR_CTRL_ADDR, 32'h0); check("flag w clr", rd, 32'h0000_0004);
        bus(1'b0, STTMR_CURR_ADDR, 32'h0);  check("curr w clr", rd, 32'h0);
    endtask : t_flag

    // Down counting steps seen through back to back reads
    task automatic t_count;
        start(32'h3E8, 32'h5);
        idle(4);
        bus(1'b0, STTMR_CURR_ADDR, 32'h0); rd_b = rd;
        bus(1'b0, STTMR_CURR_ADDR, 32'h0); check("step fast", rd_b - rd, 32'd2);
        check("count hi", {24'h0, rd[31:24]}, 32'h0);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h1);
        bus(1'b0, STTMR_CURR_ADDR, 32'h0); rd_b = rd;
        bus(1'b0, STTMR_CURR_ADDR, 32'h0); check("step slow", rd_b - rd, 32'd1);
        bus(1'b1, STTMR_CTRL_ADDR, 32'h0);
        bus(1'b0, STTMR_CURR_ADDR, 32'h0); rd_b = rd;
        idle(10);
        bus(1'b0, STTMR_CURR_ADDR, 32'h0); check("hold off", rd, rd_b);
    endtask : t_count

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("Checks done %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR timeout expected end seen none");
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_reset_map();
        t_calib_reserved();
        t_period();
        t_flag();
        t_count();
        tally_and_finish();
    end

endmodule : sttmr_top_tb
